/* File: rtl/pbr_pkg.sv */
// Purpose: Constants and types for the byte-mode reverse channel host engine
// Assumes: 25 MHz system clock, all pin inputs asynchronous to it
// Notes: Operation list follows
// Operation
// - Eight bidirectional data lines carry one whole byte per reverse transfer.
// - In reverse transfer the ack line qualifies the byte and the host samples under it.
// - In reverse idle an ack low-then-high pulse announces data and is an interrupt event.
// - The host holds init high throughout byte mode, and select-in high except to abort.
// - The host pulses strobe low per transfer and the peripheral must not latch on it.
// - The host drives autofeed low when ready to accept a reverse byte.
// - The host drives autofeed high to acknowledge a byte it has taken.
// - After a transfer, autofeed low with no data available enters reverse idle.
// - In idle the host raises autofeed on an ack low pulse to resume reverse transfer.
// - Raising autofeed while select-in is low aborts idle back to compatibility mode.
// - An output sets the direction of the data pins and any external buffer.
package pbr_pkg;

  // Host-side phases, Gray coded in listed order
  typedef enum logic [2:0] {
    PBR_COMPAT = 3'h0,
    PBR_WAIT_ACK = 3'h1,
    PBR_TAKE = 3'h3,
    PBR_WAIT_REL = 3'h2,
    PBR_STROBE = 3'h6,
    PBR_IDLE = 3'h7,
    PBR_ABORT = 3'h5
  } pbr_state_type;

  // Strobe pulse and settle time in ns, counts rounded up to whole cycles
  localparam int PBR_CLK_NS = 40;
  localparam int PBR_STROBE_NS = 500;
  localparam int PBR_STROBE_CYC = (PBR_STROBE_NS + PBR_CLK_NS - 1) / PBR_CLK_NS;
  localparam int PBR_SETTLE_NS = 200;
  localparam int PBR_SETTLE_CYC = (PBR_SETTLE_NS + PBR_CLK_NS - 1) / PBR_CLK_NS;
  localparam int PBR_CNT_W = 5;

  // Reset levels of the outputs
  localparam logic PBR_RST_AUTOFD_N = 1'h1;
  localparam logic PBR_RST_STROBE_N = 1'h1;
  localparam logic PBR_RST_SELIN_N = 1'h1;
  localparam logic PBR_RST_INIT_N = 1'h1;
  localparam logic PBR_RST_BUF_DIR_IN = 1'h0;

  // Input sync indices
  localparam int PBR_IN_ACK = 0;
  localparam int PBR_IN_FAULT = 1;
  localparam int PBR_IN_PERR = 2;
  localparam int PBR_IN_BUSY = 3;
  localparam int PBR_IN_SEL = 4;
  localparam int PBR_IN_W = 5;

endpackage

/* File: rtl/pbr_sync.sv */
// Purpose: Two-flop synchroniser for a bundle of asynchronous pin levels
// Assumes: Inputs are quasi-static levels, one clock domain
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
module pbr_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Two stages per bit, reset to the idle pin levels
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule // pbr_sync

/* File: rtl/pbr_host.sv */
// Purpose: Host end of the byte-mode reverse channel pin handshake
// Assumes: Peripheral keeps its own handshake duties; pins are asynchronous
// Notes: Single clock, no register interface; control comes on plain ports
`timescale 1ns/10ps
module pbr_host
  import pbr_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int STROBE_CYC = PBR_STROBE_CYC,
  parameter int SETTLE_CYC = PBR_SETTLE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // User side
  input wire logic byte_mode_i,
  input wire logic rx_ready_i,
  input wire logic abort_i,
  output logic [DATA_W-1:0] rx_data_o,
  output logic rx_valid_o,
  output logic data_avail_irq_o,
  output logic fwd_busy_o,
  output logic ext_response_o,
  output logic rev_idle_o,
  output logic compat_o,
  // Pins
  input wire logic [DATA_W-1:0] data_pin_i,
  output logic [DATA_W-1:0] data_pin_o,
  output logic data_pin_oe_n_o,
  input wire logic busy_i,
  input wire logic select_i,
  input wire logic ack_n_i,
  input wire logic fault_n_i,
  input wire logic perror_i,
  output logic init_n_o,
  output logic strobe_n_o,
  output logic select_in_n_o,
  output logic autofd_n_o,
  output logic buf_dir_in_o
);

  pbr_state_type state_reg, state_next;
  logic [PBR_CNT_W-1:0] cnt_reg, cnt_next;
  logic [DATA_W-1:0] data_reg, data_next;
  logic [DATA_W-1:0] dsync_meta_reg;
  logic [DATA_W-1:0] dsync_reg;
  logic rx_valid_reg, rx_valid_next;
  logic irq_reg, irq_next;
  logic autofd_reg, autofd_next;
  logic strobe_reg, strobe_next;
  logic selin_reg, selin_next;
  logic dir_in_reg, dir_in_next;
  logic busy_reg, ext_reg;
  logic ack_dly_reg;
  logic [PBR_IN_W-1:0] pins_async;
  logic [PBR_IN_W-1:0] pins_sync;
  logic ack_s, fault_s, perr_s;
  logic ack_rise;
  logic cnt_done;
  logic data_avail;

  // Control pins gathered for one synchroniser; idle levels are high for ack, fault and perror, low for busy and select
  assign pins_async = {select_i, busy_i, perror_i, fault_n_i, ack_n_i};

  pbr_sync #(
    .WIDTH(PBR_IN_W),
    .RST_VAL(5'h07)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .async_i(pins_async),
    .sync_o(pins_sync)
  );

  assign ack_s = pins_sync[PBR_IN_ACK];
  assign fault_s = pins_sync[PBR_IN_FAULT];
  assign perr_s = pins_sync[PBR_IN_PERR];
  assign ack_rise = ack_s & ~ack_dly_reg;
  assign cnt_done = (cnt_reg == '0);
  // Data available needs fault low; error mirrors fault once requested
  assign data_avail = ~fault_s;

  // Data bus sync; bytes are taken SETTLE_CYC cycles after the synchronised ack is first seen low
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dsync_meta_reg <= '0;
      dsync_reg <= '0;
      ack_dly_reg <= 1'h1;
      busy_reg <= 1'h0;
      ext_reg <= 1'h0;
    end else begin
      dsync_meta_reg <= data_pin_i;
      dsync_reg <= dsync_meta_reg;
      ack_dly_reg <= ack_s;
      busy_reg <= pins_sync[PBR_IN_BUSY];
      ext_reg <= pins_sync[PBR_IN_SEL];
    end
  end

  // Phase sequencing
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_done ? cnt_reg : cnt_reg - 1'b1;
    data_next = data_reg;
    rx_valid_next = 1'b0;
    irq_next = 1'b0;
    autofd_next = autofd_reg;
    strobe_next = strobe_reg;
    selin_next = selin_reg;
    dir_in_next = dir_in_reg;
    if (!byte_mode_i) begin
      state_next = PBR_COMPAT;
      autofd_next = PBR_RST_AUTOFD_N;
      strobe_next = PBR_RST_STROBE_N;
      selin_next = PBR_RST_SELIN_N;
      dir_in_next = PBR_RST_BUF_DIR_IN;
    end else begin
      case (state_reg)
        PBR_COMPAT: begin
          selin_next = 1'b1;
          dir_in_next = 1'b1;
          strobe_next = 1'b1;
          if (rx_ready_i) begin
            autofd_next = 1'b0;
            state_next = PBR_WAIT_ACK;
          end
        end
        PBR_WAIT_ACK: begin
          if (abort_i) begin
            selin_next = 1'b0;
            state_next = PBR_ABORT;
          end else if (!ack_s && perr_s == fault_s) begin
            // Count ends at zero, so load one less for a full SETTLE_CYC wait
            cnt_next = PBR_CNT_W'(SETTLE_CYC - 1);
            state_next = PBR_TAKE;
          end else if (!data_avail && ack_s) begin
            state_next = PBR_IDLE;
          end
        end
        PBR_TAKE: begin
          if (cnt_done) begin
            data_next = dsync_reg;
            rx_valid_next = 1'b1;
            autofd_next = 1'b1;
            state_next = PBR_WAIT_REL;
          end
        end
        PBR_WAIT_REL: begin
          if (ack_s) begin
            strobe_next = 1'b0;
            // Low for exactly STROBE_CYC cycles, including the terminal count
            cnt_next = PBR_CNT_W'(STROBE_CYC - 1);
            state_next = PBR_STROBE;
          end
        end
        PBR_STROBE: begin
          if (cnt_done) begin
            strobe_next = 1'b1;
            state_next = PBR_COMPAT;
          end
        end
        PBR_IDLE: begin
          if (abort_i) begin
            selin_next = 1'b0;
            state_next = PBR_ABORT;
          end else if (ack_rise) begin
            irq_next = 1'b1;
            autofd_next = 1'b1;
            state_next = PBR_COMPAT;
          end
        end
        PBR_ABORT: begin
          autofd_next = 1'b1;
          dir_in_next = 1'b0;
          if (!abort_i) begin
            state_next = PBR_COMPAT;
          end
        end
        default: begin
          state_next = PBR_COMPAT;
        end
      endcase
    end
  end

  // State and output flops
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg <= PBR_COMPAT;
      cnt_reg <= '0;
      data_reg <= '0;
      rx_valid_reg <= 1'b0;
      irq_reg <= 1'b0;
      autofd_reg <= PBR_RST_AUTOFD_N;
      strobe_reg <= PBR_RST_STROBE_N;
      selin_reg <= PBR_RST_SELIN_N;
      dir_in_reg <= PBR_RST_BUF_DIR_IN;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      data_reg <= data_next;
      rx_valid_reg <= rx_valid_next;
      irq_reg <= irq_next;
      autofd_reg <= autofd_next;
      strobe_reg <= strobe_next;
      selin_reg <= selin_next;
      dir_in_reg <= dir_in_next;
    end
  end

  // Status flops for the user side
  logic idle_reg, compat_reg;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      idle_reg <= 1'b0;
      compat_reg <= 1'b1;
    end else begin
      idle_reg <= (state_next == PBR_IDLE);
      compat_reg <= ~byte_mode_i | (state_next == PBR_ABORT);
    end
  end

  // Host never drives data in reverse byte mode; enable stays inactive high
  logic oe_n_reg;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= 1'b1;
    end
  end

  assign rx_data_o = data_reg;
  assign rx_valid_o = rx_valid_reg;
  assign data_avail_irq_o = irq_reg;
  assign fwd_busy_o = busy_reg;
  assign ext_response_o = ext_reg;
  assign rev_idle_o = idle_reg;
  assign compat_o = compat_reg;
  assign data_pin_o = '0;
  assign data_pin_oe_n_o = oe_n_reg;
  assign init_n_o = PBR_RST_INIT_N;
  assign strobe_n_o = strobe_reg;
  assign select_in_n_o = selin_reg;
  assign autofd_n_o = autofd_reg;
  assign buf_dir_in_o = dir_in_reg;

endmodule // pbr_host

/* File: verif/pbr_host_properties.sv */
// Purpose: Concurrent checks on the byte-mode host pins
// Assumes: Sees only the pbr_host ports
// Notes: Strobe width is counted in helper logic, not unrolled
`timescale 1ns/10ps
module pbr_host_chk #(
  parameter int STROBE_CYC = 13
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic abort_i,
  input wire logic rx_valid_o,
  input wire logic data_avail_irq_o,
  input wire logic rev_idle_o,
  input wire logic data_pin_oe_n_o,
  input wire logic busy_i,
  input wire logic select_i,
  input wire logic ack_n_i,
  input wire logic fwd_busy_o,
  input wire logic ext_response_o,
  input wire logic init_n_o,
  input wire logic strobe_n_o,
  input wire logic select_in_n_o,
  input wire logic autofd_n_o,
  input wire logic buf_dir_in_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // Low-time counter, so a long pulse needs no long repetition
  logic [7:0] low_reg;
  logic [7:0] low_next;
  assign low_next = strobe_n_o ? 8'h00 : low_reg + 8'h01;
  always_ff @(posedge clk_sys_i) low_reg <= sys_rst_i ? 8'h00 : low_next;
  // Byte taken while qualified, acknowledged on the same edge
  sequence s_ack_byte;
    $rose(autofd_n_o) ##0 !ack_n_i;
  endsequence
  a_init_high: assert property (init_n_o) else $error("init low");
  a_selin_cause: assert property ($fell(select_in_n_o) |-> $past(abort_i))
    else $error("select-in fell without abort");
  a_abort_raise: assert property ($fell(select_in_n_o) |-> ##[1:8] autofd_n_o)
    else $error("autofeed not raised in abort");
  a_dir_input: assert property (!autofd_n_o |-> buf_dir_in_o)
    else $error("pins not inputs while ready");
  a_pins_quiet: assert property (data_pin_oe_n_o) else $error("data pins driven");
  a_take_ack: assert property (rx_valid_o |-> s_ack_byte)
    else $error("byte not acknowledged");
  a_irq_resume: assert property (data_avail_irq_o |-> $rose(autofd_n_o) ##0 $past(rev_idle_o))
    else $error("irq without resume");
  a_idle_entry: assert property ($rose(rev_idle_o) |-> !autofd_n_o)
    else $error("idle with autofeed high");
  a_strobe_width: assert property (strobe_n_o && low_reg != 8'h00 |-> low_reg == 8'(STROBE_CYC))
    else $error("strobe width wrong");
  a_busy_follow: assert property (busy_i [*4] |-> fwd_busy_o)
    else $error("busy not reported");
  a_sel_follow: assert property (select_i [*4] |-> ext_response_o)
    else $error("select not reported");
endmodule // pbr_host_chk
bind pbr_host pbr_host_chk #(.STROBE_CYC(STROBE_CYC)) u_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .abort_i(abort_i), .rx_valid_o(rx_valid_o),
  .data_avail_irq_o(data_avail_irq_o), .rev_idle_o(rev_idle_o),
  .data_pin_oe_n_o(data_pin_oe_n_o), .busy_i(busy_i), .select_i(select_i), .ack_n_i(ack_n_i),
  .fwd_busy_o(fwd_busy_o), .ext_response_o(ext_response_o), .init_n_o(init_n_o),
  .strobe_n_o(strobe_n_o), .select_in_n_o(select_in_n_o), .autofd_n_o(autofd_n_o),
  .buf_dir_in_o(buf_dir_in_o));

/* File: verif/pbr_periph.sv */
// Purpose: Behavioural byte-mode peripheral
// Assumes: Bench controls data, pace and status levels
// Notes: Released data lines toggle so stale values never pass
`timescale 1ns/10ps
module pbr_periph (
  input wire logic clk_sys_i,
  input wire logic has_data_i,
  input wire logic slow_i,
  input wire logic irq_req_i,
  input wire logic [7:0] byte_i,
  input wire logic busy_cmd_i,
  input wire logic sel_cmd_i,
  input wire logic autofd_n_i,
  output logic [7:0] data_o,
  output logic ack_n_o,
  output logic fault_n_o,
  output logic perror_o,
  output logic busy_o,
  output logic select_o
);
  logic [3:0] dly_reg = 4'h0;
  logic req;
  assign req = !autofd_n_i && has_data_i;
  // Strobe is not an input here, so it can never latch data
  initial begin
    data_o = 8'h00;
    ack_n_o = 1'b1;
  end
  // Data first, ack one or eight cycles later, released on autofeed high
  always @(posedge clk_sys_i) begin
    dly_reg <= !req ? 4'h0 : (dly_reg == 4'hF) ? dly_reg : dly_reg + 4'h1;
    data_o <= req ? byte_i : ~data_o;
    ack_n_o <= !(irq_req_i || (req && dly_reg >= (slow_i ? 4'h8 : 4'h1)));
    fault_n_o <= !has_data_i;
    perror_o <= autofd_n_i ? 1'b1 : fault_n_o;
    busy_o <= busy_cmd_i;
    select_o <= sel_cmd_i;
  end
endmodule // pbr_periph

/* File: verif/pbr_host_tb_top.sv */
// Purpose: Self-checking bench for the byte-mode host
// Assumes: Short strobe and settle counts
// Notes: Every wait is bounded and ends the run on overflow
`timescale 1ns/10ps
module pbr_host_tb_top;
  import pbr_pkg::*;
  localparam int STB = 3;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic byte_mode = 1'b1;
  logic rx_ready_i = 1'b0;
  logic abort_i = 1'b0;
  logic has_data = 1'b0;
  logic slow = 1'b0;
  logic irq_req = 1'b0;
  logic busy_cmd = 1'b0;
  logic sel_cmd = 1'b0;
  logic [7:0] byte_v = 8'h00;
  logic [7:0] rx_data_o, pdata, data_pin_o, pins;
  logic rx_valid_o, data_avail_irq_o, fwd_busy_o, ext_response_o, rev_idle_o, compat_o;
  logic data_pin_oe_n_o, busy_i, select_i, ack_n_i, fault_n_i, perror_i;
  logic init_n_o, strobe_n_o, select_in_n_o, autofd_n_o, buf_dir_in_o;
  int errors = 0;
  int checked = 0;
  int n;
  always #20 clk_sys_i = ~clk_sys_i;
  // Wire level from the host's enable alone; the peripheral drives whenever the host does not
  assign pins = data_pin_oe_n_o ? pdata : data_pin_o;
  pbr_host #(.STROBE_CYC(STB), .SETTLE_CYC(2)) dut (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .byte_mode_i(byte_mode), .rx_ready_i(rx_ready_i), .abort_i(abort_i),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .data_avail_irq_o(data_avail_irq_o),
    .fwd_busy_o(fwd_busy_o), .ext_response_o(ext_response_o), .rev_idle_o(rev_idle_o),
    .compat_o(compat_o), .data_pin_i(pins), .data_pin_o(data_pin_o),
    .data_pin_oe_n_o(data_pin_oe_n_o), .busy_i(busy_i), .select_i(select_i),
    .ack_n_i(ack_n_i), .fault_n_i(fault_n_i), .perror_i(perror_i), .init_n_o(init_n_o),
    .strobe_n_o(strobe_n_o), .select_in_n_o(select_in_n_o), .autofd_n_o(autofd_n_o),
    .buf_dir_in_o(buf_dir_in_o));
  pbr_periph u_per (.clk_sys_i(clk_sys_i), .has_data_i(has_data), .slow_i(slow),
    .irq_req_i(irq_req), .byte_i(byte_v), .busy_cmd_i(busy_cmd), .sel_cmd_i(sel_cmd),
    .autofd_n_i(autofd_n_o), .data_o(pdata), .ack_n_o(ack_n_i), .fault_n_o(fault_n_i),
    .perror_o(perror_i), .busy_o(busy_i), .select_o(select_i));
  task automatic results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tmo(input int k);
    if (k >= 300) begin
      errors++;
      $display("ERROR wait expected done seen timeout");
      results();
    end
  endtask
  task automatic request;
    rx_ready_i <= 1'b1;
    for (n = 0; n < 300 && autofd_n_o; n++) @(posedge clk_sys_i);
    tmo(n);
    rx_ready_i <= 1'b0;
  endtask
  // One reverse byte, prompt or slow peripheral
  task automatic t_byte(input logic [7:0] b, input logic s);
    byte_v <= b;
    has_data <= 1'b1;
    slow <= s;
    // Fault must pass the synchroniser first, or the host sees no data and idles
    repeat (4) @(posedge clk_sys_i);
    request();
    for (n = 0; n < 300 && !rx_valid_o; n++) @(posedge clk_sys_i);
    tmo(n);
    chk("rx_data", b, rx_data_o);
    chk("buf_dir", 8'h01, {7'h0, buf_dir_in_o});
    @(posedge clk_sys_i);
    chk("autofd_ack", 8'h01, {7'h0, autofd_n_o});
    for (n = 0; n < 300 && strobe_n_o; n++) @(posedge clk_sys_i);
    tmo(n);
    repeat (STB) @(posedge clk_sys_i);
    chk("strobe_end", 8'h01, {7'h0, strobe_n_o});
    $display("byte %h done", b);
  endtask
  // No data: idle, then announce and resume
  task automatic t_idle;
    has_data <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    request();
    for (n = 0; n < 300 && !rev_idle_o; n++) @(posedge clk_sys_i);
    tmo(n);
    chk("autofd_idle", 8'h00, {7'h0, autofd_n_o});
    irq_req <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    irq_req <= 1'b0;
    for (n = 0; n < 300 && !data_avail_irq_o; n++) @(posedge clk_sys_i);
    tmo(n);
    @(posedge clk_sys_i);
    chk("autofd_resume", 8'h01, {7'h0, autofd_n_o});
    $display("idle done");
  endtask
  // Abort from idle back to compatibility
  task automatic t_abort;
    repeat (20) @(posedge clk_sys_i);
    request();
    for (n = 0; n < 300 && !rev_idle_o; n++) @(posedge clk_sys_i);
    tmo(n);
    abort_i <= 1'b1;
    for (n = 0; n < 300 && !(autofd_n_o && compat_o); n++) @(posedge clk_sys_i);
    tmo(n);
    chk("selin_abort", 8'h00, {7'h0, select_in_n_o});
    abort_i <= 1'b0;
    for (n = 0; n < 300 && !select_in_n_o; n++) @(posedge clk_sys_i);
    tmo(n);
    $display("abort done");
  endtask
  // Byte mode off forces compatibility and idle pin levels
  task automatic t_mode;
    byte_mode <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk("mode_off", 8'h0E, {4'h0, compat_o, autofd_n_o, select_in_n_o, buf_dir_in_o});
    byte_mode <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk("mode_on", 8'h01, {6'h0, compat_o, buf_dir_in_o});
    $display("mode done");
  endtask
  // Status pins reach the user side
  task automatic t_status;
    busy_cmd <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    chk("status1", 8'h02, {6'h0, fwd_busy_o, ext_response_o});
    busy_cmd <= 1'b0;
    sel_cmd <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    chk("status2", 8'h01, {6'h0, fwd_busy_o, ext_response_o});
    $display("status done");
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("reset", 8'h3E, {2'h0, compat_o, strobe_n_o, autofd_n_o, select_in_n_o, init_n_o,
      buf_dir_in_o});
    t_status();
    t_byte(8'hA5, 1'b0);
    t_byte(8'h00, 1'b0);
    t_byte(8'hFF, 1'b1);
    t_byte(8'h5A, 1'b1);
    t_idle();
    t_abort();
    t_mode();
    results();
  end
endmodule // pbr_host_tb_top
